//--- hdl/sfwb_core.sv
// serial command front end: burst wrap, page buffer, buffer program
`timescale 1ns/1ps
`include "sfwb_map.svh"

module sfwb_core
  import sfwb_pkg::*;
#(
  parameter int PROG_CYCLES = `SFWB_T_PP_CYC
) (
  input logic clock,
  input logic rst_b,
  input logic sck,
  input logic csB,
  input logic [3:0] sioIn,
  output logic soOut,
  output logic soOe,
  input logic welFlag,
  output logic welClear,
  output logic readyBusy,
  output logic wrapEnable,
  output logic [1:0] wrapSize,
  output logic [6:0] wrapLength,
  output logic arrValid,
  input logic arrReady,
  output logic [23:0] arrAddr,
  output sfwb_byte_t arrData
);

  function automatic logic [6:0] wrapLen(input logic [1:0] sz);
    wrapLen = `SFWB_WRAP_BASE_LEN << sz;
  endfunction

  // ---------------- link side, clocked by sck ----------------

  logic frameRst_b;
  assign frameRst_b = rst_b & ~csB;

  // per-frame counters, cleared while chip select is high
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [2:0] bitPos_r;
  logic [2:0] bitPos_nxt;
  sfwb_byte_t sh_r;
  sfwb_byte_t sh_nxt;
  logic quad;

  // frame results, kept after chip select rises for the core side
  sfwb_byte_t opcode_r;
  sfwb_byte_t opcode_nxt;
  sfwb_byte_t wrapByte_r;
  sfwb_byte_t wrapByte_nxt;
  logic [15:0] page_r;
  logic [15:0] page_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [5:0] lastCnt_r;
  logic [5:0] lastCnt_nxt;
  logic aligned_r;
  logic aligned_nxt;
  logic tog_r;
  logic tog_nxt;
  logic welS1_r;
  logic welS2_r;
  logic bufWrite;
  logic rdStep;

  sfwb_byte_t buf_r [256];
  // writes go to the other copy until the frame ends on a byte
  sfwb_byte_t bufB_r [256];
  logic [255:0] selB_r, selB_nxt, pend_r, pend_nxt;

  always_comb begin
    quad = (opcode_r == `SFWB_OP_WRAP) && (cnt_r >= `SFWB_CNT_CMD);
    cnt_nxt = (cnt_r == `SFWB_CNT_MAX) ? cnt_r : cnt_r + 6'h01;
    bitPos_nxt = bitPos_r + (quad ? 3'h4 : 3'h1);
    sh_nxt = quad ? {sh_r[3:0], sioIn} : {sh_r[6:0], sioIn[0]};
  end

  always_ff @(posedge sck or negedge frameRst_b) begin
    if (!frameRst_b) begin
      cnt_r <= 6'h00;
      bitPos_r <= 3'h0;
      sh_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      bitPos_r <= bitPos_nxt;
      sh_r <= sh_nxt;
    end
  end

  always_comb begin
    opcode_nxt = opcode_r;
    wrapByte_nxt = wrapByte_r;
    page_nxt = page_r;
    ptr_nxt = ptr_r;
    tog_nxt = tog_r;
    lastCnt_nxt = cnt_nxt;
    aligned_nxt = (bitPos_nxt == 3'h0);
    selB_nxt = selB_r;
    pend_nxt = bufWrite ? pend_r | (256'h1 << ptr_r) : pend_r;
    // last frame's writes are adopted or dropped at this frame's start
    if (cnt_r == 6'h00) begin
      selB_nxt = aligned_r ? selB_r ^ pend_r : selB_r;
      pend_nxt = '0;
    end
    // one toggle per frame tells the core side a new frame ran
    if (cnt_r == 6'h00) begin
      tog_nxt = ~tog_r;
    end
    // opcode msb first over eight clocks
    if (cnt_nxt == `SFWB_CNT_CMD) begin
      opcode_nxt = sh_nxt;
    end
    // address nibbles are shifted but never stored
    if (quad && cnt_nxt == `SFWB_CNT_WRAP) begin
      wrapByte_nxt = sh_nxt;
    end
    if (!quad && cnt_nxt == `SFWB_CNT_PAGE_HI) begin
      page_nxt[15:8] = sh_nxt;
    end
    if (!quad && cnt_nxt == `SFWB_CNT_PAGE_LO) begin
      page_nxt[7:0] = sh_nxt;
    end
    if (!quad && cnt_nxt == `SFWB_CNT_ADDR) begin
      ptr_nxt = sh_nxt;
    end else if (bufWrite || rdStep) begin
      ptr_nxt = ptr_r + 8'h01;
    end
  end

  // write lands only on a whole byte and with the latch set
  assign bufWrite = (opcode_r == `SFWB_OP_BUF_WR)
    && (cnt_r >= `SFWB_CNT_ADDR) && (bitPos_nxt == 3'h0)
    && welS2_r;
  // data phase starts after the dummy byte
  assign rdStep = (opcode_r == `SFWB_OP_BUF_RD)
    && (cnt_r >= `SFWB_CNT_DUMMY) && (bitPos_nxt == 3'h0);

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      opcode_r <= 8'h00;
      wrapByte_r <= 8'h00;
      page_r <= 16'h0000;
      ptr_r <= 8'h00;
      lastCnt_r <= 6'h00;
      aligned_r <= 1'b1;
      tog_r <= 1'b0;
      selB_r <= '0;
      pend_r <= '0;
      welS1_r <= 1'b0;
      welS2_r <= 1'b0;
    end else begin
      opcode_r <= opcode_nxt;
      wrapByte_r <= wrapByte_nxt;
      page_r <= page_nxt;
      ptr_r <= ptr_nxt;
      lastCnt_r <= lastCnt_nxt;
      aligned_r <= aligned_nxt;
      tog_r <= tog_nxt;
      selB_r <= selB_nxt;
      pend_r <= pend_nxt;
      welS1_r <= welFlag;
      welS2_r <= welS1_r;
    end
  end

  // no reset and no clear: untouched entries keep old data
  always_ff @(posedge sck) begin
    if (bufWrite && selB_r[ptr_r]) begin
      buf_r[ptr_r] <= sh_nxt;
    end else if (bufWrite) begin
      bufB_r[ptr_r] <= sh_nxt;
    end
  end

  // read data launched on the falling edge, sampled by host on rise
  sfwb_byte_t outSh_r;
  sfwb_byte_t outSh_nxt;
  logic outEn_r;
  logic outEn_nxt;
  logic rdLoad;
  sfwb_byte_t rdData;

  always_comb begin
    rdData = selB_r[ptr_r] ? bufB_r[ptr_r] : buf_r[ptr_r];
    rdLoad = (opcode_r == `SFWB_OP_BUF_RD)
      && (cnt_r >= `SFWB_CNT_DUMMY) && (bitPos_r == 3'h0);
    outEn_nxt = outEn_r | rdLoad;
    outSh_nxt = rdLoad ? rdData : {outSh_r[6:0], 1'b0};
  end

  always_ff @(negedge sck or negedge frameRst_b) begin
    if (!frameRst_b) begin
      outSh_r <= 8'h00;
      outEn_r <= 1'b0;
    end else begin
      outSh_r <= outSh_nxt;
      outEn_r <= outEn_nxt;
    end
  end

  assign soOut = outSh_r[7];
  // released at once by chip select, mid-byte or not
  assign soOe = outEn_r & ~csB;

  // ---------------- core side, clocked by clock ----------------

  logic csS1_r;
  logic csS2_r;
  logic csS3_r;
  logic togS1_r;
  logic togS2_r;
  logic seen_r;
  logic seen_nxt;
  logic wrapDis_r;
  logic wrapDis_nxt;
  logic [1:0] wrapSize_r;
  logic [1:0] wrapSize_nxt;
  logic welClear_r;
  logic welClear_nxt;
  logic progStart_r;
  logic progStart_nxt;
  logic frameEnd;
  logic progBusy;
  logic progWelDrop;
  logic [7:0] progIdx;

  // link results are static once sck has stopped and cs is high
  assign frameEnd = csS2_r & ~csS3_r & (togS2_r != seen_r);

  always_comb begin
    seen_nxt = seen_r;
    wrapDis_nxt = wrapDis_r;
    wrapSize_nxt = wrapSize_r;
    welClear_nxt = progWelDrop;
    progStart_nxt = 1'b0;
    if (frameEnd) begin
      seen_nxt = togS2_r;
      case (opcode_r)
        `SFWB_OP_WRAP: begin
          // misaligned or short frame leaves the setting alone
          if (aligned_r && lastCnt_r >= `SFWB_CNT_WRAP) begin
            wrapDis_nxt = wrapByte_r[`SFWB_WRAP_DIS_BIT];
            wrapSize_nxt = wrapByte_r[`SFWB_WRAP_SIZE_HI:
                                      `SFWB_WRAP_SIZE_LO];
          end
        end
        `SFWB_OP_BUF_PROG: begin
          if (aligned_r) begin
            if (lastCnt_r < `SFWB_CNT_ADDR) begin
              welClear_nxt = 1'b1;
            end else if (welFlag && !progBusy) begin
              progStart_nxt = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csS3_r <= 1'b1;
      togS1_r <= 1'b0;
      togS2_r <= 1'b0;
      seen_r <= 1'b0;
      wrapDis_r <= `SFWB_WRAP_DIS_RST;
      wrapSize_r <= `SFWB_WRAP_SIZE_RST;
      welClear_r <= 1'b0;
      progStart_r <= 1'b0;
    end else begin
      csS1_r <= csB;
      csS2_r <= csS1_r;
      csS3_r <= csS2_r;
      togS1_r <= tog_r;
      togS2_r <= togS1_r;
      seen_r <= seen_nxt;
      wrapDis_r <= wrapDis_nxt;
      wrapSize_r <= wrapSize_nxt;
      welClear_r <= welClear_nxt;
      progStart_r <= progStart_nxt;
    end
  end

  // buffer is read here from the adopted copy, never the copy that a frame writes
  sfwb_page_prog #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_prog (
    .clock(clock),
    .rst_b(rst_b),
    .start(progStart_r),
    .pageIn(page_r),
    .byteIn(selB_r[progIdx] ? bufB_r[progIdx] : buf_r[progIdx]),
    .byteIdx(progIdx),
    .arrValid(arrValid),
    .arrReady(arrReady),
    .arrAddr(arrAddr),
    .arrData(arrData),
    .busy(progBusy),
    .welDrop(progWelDrop)
  );

  assign readyBusy = progBusy;
  assign welClear = welClear_r;
  // quad read logic limits its burst to this length when enabled
  assign wrapEnable = ~wrapDis_r;
  assign wrapSize = wrapSize_r;
  assign wrapLength = wrapLen(wrapSize_r);

endmodule

//--- hdl/sfwb_map.svh
// offsets, opcodes, field positions, reset values and timing counts
`ifndef SFWB_MAP_SVH
`define SFWB_MAP_SVH

`define SFWB_OP_WRAP 8'h77
`define SFWB_OP_BUF_RD 8'hD4
`define SFWB_OP_BUF_WR 8'h84
`define SFWB_OP_BUF_PROG 8'h88

`define SFWB_CNT_CMD 6'h08
`define SFWB_CNT_WRAP 6'h10
`define SFWB_CNT_PAGE_HI 6'h10
`define SFWB_CNT_PAGE_LO 6'h18
`define SFWB_CNT_ADDR 6'h20
`define SFWB_CNT_DUMMY 6'h28
`define SFWB_CNT_MAX 6'h3F

`define SFWB_WRAP_DIS_BIT 4
`define SFWB_WRAP_SIZE_HI 6
`define SFWB_WRAP_SIZE_LO 5
`define SFWB_WRAP_DIS_RST 1'b1
`define SFWB_WRAP_SIZE_RST 2'h0
`define SFWB_WRAP_BASE_LEN 7'h08

`define SFWB_PAGE_LAST 8'hFF

`define SFWB_CLK_MHZ 10
`define SFWB_T_PP_US 3000
`define SFWB_T_PP_CYC (`SFWB_T_PP_US * `SFWB_CLK_MHZ)

`endif

//--- hdl/sfwb_pkg.sv
// shared types for the serial flash wrap and page buffer block
package sfwb_pkg;

  typedef logic [7:0] sfwb_byte_t;

  typedef enum logic [1:0] {
    PG_IDLE,
    PG_LOAD,
    PG_SEND,
    PG_WAIT
  } sfwb_prog_e;

endpackage

//--- hdl/sfwb_page_prog.sv
// self-timed copy of the page buffer into one main-array page
`timescale 1ns/1ps
`include "sfwb_map.svh"

module sfwb_page_prog
  import sfwb_pkg::*;
#(
  parameter int PROG_CYCLES = `SFWB_T_PP_CYC
) (
  input logic clock,
  input logic rst_b,
  input logic start,
  input logic [15:0] pageIn,
  input sfwb_byte_t byteIn,
  output logic [7:0] byteIdx,
  output logic arrValid,
  input logic arrReady,
  output logic [23:0] arrAddr,
  output sfwb_byte_t arrData,
  output logic busy,
  output logic welDrop
);

  localparam int TW = $clog2(PROG_CYCLES + 1);

  sfwb_prog_e state_r, state_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [15:0] page_r, page_nxt;
  sfwb_byte_t data_r, data_nxt;
  logic [TW-1:0] timer_r, timer_nxt;
  logic welDrop_r, welDrop_nxt;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    page_nxt = page_r;
    data_nxt = data_r;
    welDrop_nxt = 1'b0;
    timer_nxt = timer_r;
    if (state_r != PG_IDLE && timer_r != TW'(PROG_CYCLES)) begin
      timer_nxt = timer_r + TW'(1);
    end
    case (state_r)
      PG_IDLE: begin
        if (start) begin
          state_nxt = PG_LOAD;
          page_nxt = pageIn;
          idx_nxt = 8'h00;
          timer_nxt = '0;
        end
      end
      PG_LOAD: begin
        data_nxt = byteIn;
        state_nxt = PG_SEND;
      end
      PG_SEND: begin
        if (arrReady) begin
          // every entry goes out, written or not
          if (idx_r == `SFWB_PAGE_LAST) begin
            state_nxt = PG_WAIT;
            welDrop_nxt = 1'b1;
          end else begin
            idx_nxt = idx_r + 8'h01;
            state_nxt = PG_LOAD;
          end
        end
      end
      PG_WAIT: begin
        // finish no earlier than the page program time
        if (timer_r >= TW'(PROG_CYCLES - 1)) begin
          state_nxt = PG_IDLE;
        end
      end
      default: state_nxt = PG_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PG_IDLE;
      idx_r <= 8'h00;
      page_r <= 16'h0000;
      data_r <= 8'h00;
      timer_r <= '0;
      welDrop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      page_r <= page_nxt;
      data_r <= data_nxt;
      timer_r <= timer_nxt;
      welDrop_r <= welDrop_nxt;
    end
  end

  assign byteIdx = idx_r;
  assign arrValid = (state_r == PG_SEND);
  assign arrAddr = {page_r, idx_r};
  assign arrData = data_r;
  assign busy = (state_r != PG_IDLE);
  assign welDrop = welDrop_r;

endmodule

//--- tb/sfwb_core_monitor.sv
// concurrent checks on the ports of the wrap and page buffer core
`timescale 1ns/1ps
module sfwb_core_monitor
  import sfwb_pkg::*;
#(
  parameter int PROG_CYCLES = 600
) (
  input logic clock,
  input logic rst_b,
  input logic csB,
  input logic soOe,
  input logic welClear,
  input logic readyBusy,
  input logic wrapEnable,
  input logic [1:0] wrapSize,
  input logic [6:0] wrapLength,
  input logic arrValid,
  input logic arrReady,
  input logic [23:0] arrAddr,
  input sfwb_byte_t arrData
);
  int busyCnt_r, busyCnt_nxt;
  logic [7:0] nextIdx_r, nextIdx_nxt;
  // next index survives between programs, since each copy ends on 255
  always_comb begin
    busyCnt_nxt = readyBusy ? busyCnt_r + 1 : 0;
    nextIdx_nxt = arrValid && arrReady ? arrAddr[7:0] + 8'h01 : nextIdx_r;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt_r <= 0;
      nextIdx_r <= 8'h00;
    end else begin
      busyCnt_r <= busyCnt_nxt;
      nextIdx_r <= nextIdx_nxt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_oe_chip_sel: assert property (soOe |-> !csB)
    else $error("output driven while deselected");
  a_size_length: assert property (wrapLength == 7'h08 << wrapSize)
    else $error("wrap length wrong");
  a_wrap_frame_end: assert property (
    !$stable({wrapEnable, wrapSize}) |-> csB && $past(csB, 2))
    else $error("wrap changed inside frame");
  a_valid_hold: assert property (arrValid && !arrReady |=>
    arrValid && $stable(arrAddr) && $stable(arrData))
    else $error("array byte dropped");
  a_valid_busy: assert property (arrValid |-> readyBusy)
    else $error("array write while ready");
  a_clear_pulse: assert property (welClear |=> !welClear)
    else $error("clear request too long");
  a_next_entry: assert property (
    $rose(arrValid) |-> arrAddr[7:0] == nextIdx_r)
    else $error("array index skipped");
  a_busy_time: assert property (
    $fell(readyBusy) |-> busyCnt_r >= PROG_CYCLES - 2)
    else $error("program ended early");
endmodule

bind sfwb_core sfwb_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_u (
  .clock, .rst_b, .csB, .soOe, .welClear, .readyBusy, .wrapEnable,
  .wrapSize, .wrapLength, .arrValid, .arrReady, .arrAddr, .arrData
);

//--- tb/sfwb_host_model.sv
// spi host model: mode 0 frames, single or quad lines
`timescale 1ns/1ps
module sfwb_host_model (
  output logic sck,
  output logic csB,
  output logic [3:0] sioIn,
  input logic soOut,
  input logic soOe
);
  logic tog = 1'b0;
  initial begin
    sck = 1'b0;
    csB = 1'b1;
    sioIn = 4'h0;
  end
  // idle lines toggle so a stale level never passes for data
  task automatic tick(input logic [3:0] d, input bit q, output logic so);
    tog = ~tog;
    sioIn = q ? d : {tog, ~tog, soOe ? soOut : tog, d[0]};
    #32 sck = 1'b1;
    so = soOut;
    #32 sck = 1'b0;
  endtask
  task automatic put(input logic [7:0] v, input bit q);
    logic so;
    if (q) begin
      tick(v[7:4], 1'b1, so);
      tick(v[3:0], 1'b1, so);
    end else begin
      for (int i = 7; i >= 0; i--) tick({3'h0, v[i]}, 1'b0, so);
    end
  endtask
  task automatic get(input int n, output logic [7:0] v);
    logic so;
    for (int i = 0; i < n; i++) begin
      tick({3'h0, tog}, 1'b0, so);
      v = {v[6:0], so};
    end
  endtask
  task automatic open();
    csB = 1'b0;
    #32;
  endtask
  // no data phase here keeps the program frame bare
  task automatic close();
    #32 csB = 1'b1;
    #600;
  endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the wrap and page buffer core
`timescale 1ns/1ps
`include "sfwb_map.svh"
module tb;
  import sfwb_pkg::*;
  localparam int PROG = 1200;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic welFlag = 1'b0;
  logic arrReady = 1'b0;
  logic sck, csB, soOut, soOe, welClear, readyBusy, wrapEnable, arrValid;
  logic [3:0] sioIn;
  logic [1:0] wrapSize;
  logic [6:0] wrapLength;
  logic [23:0] arrAddr, page;
  sfwb_byte_t arrData, bufM [256];
  logic [7:0] v, w, a8;
  logic [9:0] e;
  logic [31:0] seed = 32'h0000_005D;
  logic [31:0] expQ [$];
  int err_count = 0;
  int comparisons = 0;
  int clears = 0;

  sfwb_core #(.PROG_CYCLES(PROG)) dut_u (.clock, .rst_b, .sck, .csB,
    .sioIn, .soOut, .soOe, .welFlag, .welClear, .readyBusy, .wrapEnable,
    .wrapSize, .wrapLength, .arrValid, .arrReady, .arrAddr, .arrData);
  sfwb_host_model host_u (.sck, .csB, .sioIn, .soOut, .soOe);

  always #50 clock = ~clock;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [31:0] seen, want, input string msg);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // array stalls at random; the latch drops on a clear request
  always @(posedge clock) begin
    arrReady <= rnd() > 8'h50;
    if (welClear === 1'b1) begin
      welFlag <= 1'b0;
      clears <= clears + 1;
    end
  end

  always @(posedge clock) begin
    if (arrValid === 1'b1 && arrReady === 1'b1) begin
      check({arrAddr, arrData}, expQ.pop_front(), "array byte");
    end
  end

  task automatic wrap(input logic [7:0] b, input int extra);
    host_u.open();
    host_u.put(`SFWB_OP_WRAP, 1'b0);
    repeat (3) host_u.put(rnd(), 1'b1);
    host_u.put(b, 1'b1);
    if (extra > 0) host_u.get(extra, v);
    host_u.close();
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    host_u.open();
    host_u.put(op, 1'b0);
    for (int i = 2; i >= 0; i--) host_u.put(a[i*8 +: 8], 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    check({wrapEnable, wrapLength}, 32'h0000_0008, "reset wrap");
    for (int i = 0; i < 5; i++) begin
      w = rnd();
      w[6:4] = {i[1:0], i == 4};
      e = {!w[4], w[6:5], 7'h08 << w[6:5]};
      wrap(w, 0);
      check({wrapEnable, wrapSize, wrapLength}, e, "wrap set");
    end
    wrap(w ^ 8'h70, 3);
    check({wrapEnable, wrapSize, wrapLength}, e, "wrap abort");
    $display("wrap tests done");
    @(posedge clock) welFlag <= 1'b1;
    cmd(`SFWB_OP_BUF_WR, {rnd(), rnd(), 8'hFE});
    a8 = 8'hFE;
    repeat (258) begin
      bufM[a8] = rnd();
      host_u.put(bufM[a8], 1'b0);
      a8++;
    end
    host_u.close();
    cmd(`SFWB_OP_BUF_WR, 24'h00_0010);
    host_u.put(~bufM[8'h10], 1'b0);
    host_u.get(5, v);
    host_u.close();
    @(posedge clock) welFlag <= 1'b0;
    cmd(`SFWB_OP_BUF_WR, 24'h00_0020);
    host_u.put(~bufM[8'h20], 1'b0);
    host_u.close();
    cmd(`SFWB_OP_BUF_RD, {rnd(), rnd(), 8'hFE});
    host_u.put(rnd(), 1'b0);
    a8 = 8'hFE;
    repeat (36) begin
      host_u.get(8, v);
      check(v, bufM[a8], "buffer read");
      a8++;
    end
    check(soOe, 1'b1, "output driven");
    host_u.get(3, v);
    host_u.close();
    check(soOe, 1'b0, "output released");
    $display("buffer tests done");
    page = {rnd(), rnd(), 8'h00};
    for (int k = 0; k < 256; k++) begin
      expQ.push_back({page[23:8], k[7:0], bufM[k]});
    end
    @(posedge clock) welFlag <= 1'b1;
    cmd(`SFWB_OP_BUF_PROG, {page[23:8], rnd()});
    host_u.close();
    check(readyBusy, 1'b1, "busy");
    for (int n = 0; readyBusy !== 1'b0; n++) begin
      if (n > 5000) begin
        err_count++;
        give_verdict();
      end
      @(posedge clock);
    end
    repeat (2) @(posedge clock);
    check(clears, 1, "latch clear");
    check(expQ.size(), 0, "bytes left");
    cmd(`SFWB_OP_BUF_PROG, 24'h00_0000);
    host_u.close();
    check(readyBusy, 1'b0, "program refused");
    $display("program tests done");
    give_verdict();
  end
endmodule
